// ---- hw/mdt_display_seq.sv ----
/*
   maintenance display-transfer sequencer with its AXI4-Lite register
   slave: runs the switch-to-display, register-to-display and
   memory-to-display commands against the partner's time-slot logic.
   assumes: partner logic runs on aclk, upcoming_vp names the VP current
   two clocks later, memory_data_bus is driven while an enable is high.

*/
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
module mdt_display_seq (
   // clock and reset
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   // axi4-lite write address
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [mdt_pkg::ADDR_W-1:0]    s_axi_awaddr,
   // axi4-lite write data
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   input  wire logic [mdt_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [mdt_pkg::DATA_W/8-1:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   output logic [1:0]                         s_axi_bresp,
   // axi4-lite read address
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   input  wire logic [mdt_pkg::ADDR_W-1:0]    s_axi_araddr,
   // axi4-lite read data
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   output logic [mdt_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   // time-slot control and buffer side
   input  wire mdt_pkg::mdt_vp_in_type        vp_in,
   output mdt_pkg::mdt_vp_out_type            vp_out
);
   import mdt_pkg::*;

   typedef struct packed {
      mdt_state_type           st;
      logic                    entered;
      mdt_ctrl_type            ctrl;
      logic                    busy;
      logic                    illegal;
      logic [DATA_W-1:0]       sw;
      logic [DATA_W-1:0]       disp;
      logic [DONE_W-1:0]       done_cnt;
      mdt_vp_out_type          out;
      logic                    aw_have;
      logic [ADDR_W-1:0]       aw_addr;
      logic                    w_have;
      logic [DATA_W-1:0]       w_data;
      logic [DATA_W/8-1:0]     w_strb;
      logic                    bvalid;
      logic [1:0]              bresp;
      logic                    rvalid;
      logic [DATA_W-1:0]       rdata;
      logic [1:0]              rresp;
   } mdt_core_type;

   mdt_core_type   q;
   mdt_core_type   d;
   mdt_ctrl_type   nw_ctrl;
   mdt_status_type stat;
   logic           auto_mode;
   logic           vp_field_match;
   logic           illegal_cmd_detect;
   logic           go_ok;
   logic           fire;
   logic           finish;
   logic           reserve;

   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0]   old,
                                               input logic [DATA_W-1:0]   nw,
                                               input logic [DATA_W/8-1:0] strb);
      merge = old;
      for (int i = 0; i < DATA_W/8; i++) begin
         if (strb[i]) begin
            merge[8*i +: 8] = nw[8*i +: 8];
         end
      end
   endfunction

   function automatic logic [2:0] state_code(input mdt_state_type st);
      case (st)
         MDT_WAIT:  state_code = SCODE_WAIT;
         MDT_XFER:  state_code = SCODE_XFER;
         MDT_READ:  state_code = SCODE_READ;
         MDT_FINAL: state_code = SCODE_FINAL;
         default:   state_code = SCODE_IDLE;
      endcase
   endfunction

   function automatic logic [REG_TYPES-1:0] reg_onehot(input logic [3:0] sel);
      reg_onehot = '0;
      if (sel <= RSEL_MICRO) begin
         reg_onehot[sel] = 1'b1;
      end
   endfunction

   function automatic logic cmd_known(input logic [3:0] cmd);
      cmd_known = (cmd == CMD_SR_TO_DR) || (cmd == CMD_REG_TO_DR)
               || (cmd == CMD_MEM_TO_DR);
   endfunction

   mdt_dwell_timer u_dwell (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .restart   (q.entered),
      .auto_mode (auto_mode),
      .fire      (fire)
   );

   // partner conditions, all on aclk
   always_comb begin
      auto_mode = q.ctrl.mode == MODE_AUTO;
      // upcoming_vp already names the VP two slots ahead
      vp_field_match = vp_in.upcoming_vp == q.ctrl.vp;
      illegal_cmd_detect = (q.ctrl.cmd == CMD_REG_TO_DR)
                        && ((auto_mode && q.ctrl.reg_sel == RSEL_MICRO)
                        || (q.ctrl.reg_sel > RSEL_MICRO));
      // memory read also needs the buffer free for that VP
      go_ok = !auto_mode || (vp_field_match
           && (q.ctrl.cmd != CMD_MEM_TO_DR || vp_in.buffer_avail_for_vp));
      stat = '0;
      stat.busy = q.busy;
      stat.illegal = q.illegal;
      stat.state_code = state_code(q.st);
      stat.vp_match = vp_field_match;
   end

   always_comb begin
      d = q;
      finish = 1'b0;
      reserve = 1'b0;
      nw_ctrl = merge(q.ctrl, q.w_data, q.w_strb);
      nw_ctrl.rsvd_hi = '0;
      nw_ctrl.rsvd_mid = 1'b0;

      // pulses last one cycle; data outputs follow their sources
      d.out = '0;
      d.out.target_vp = q.ctrl.vp;
      d.out.arith_b_bus = q.sw;

      // display captures while the load gate is out
      if (q.out.display_load_gate) begin
         d.disp = q.out.display_source_select ? q.sw : vp_in.memory_data_bus;
      end

      // write channels are taken independently, in either order
      if (s_axi_awvalid && s_axi_awready) begin
         d.aw_have = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         d.w_have = 1'b1;
         d.w_data = s_axi_wdata;
         d.w_strb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_have && q.w_have) begin
         d.aw_have = 1'b0;
         d.w_have = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = RESP_OKAY;
         if (q.aw_addr == OFS_CTRL) begin
            // fields are locked while a command is under way
            if (q.st == MDT_IDLE && q.ctrl.cmd == CMD_NOP) begin
               d.ctrl.mode = nw_ctrl.mode;
               d.ctrl.vp = nw_ctrl.vp;
               d.ctrl.reg_sel = nw_ctrl.reg_sel;
               if (cmd_known(nw_ctrl.cmd)) begin
                  d.ctrl.cmd = nw_ctrl.cmd;
               end
            end else if (q.st == MDT_FINAL && q.illegal
                         && nw_ctrl.cmd == CMD_NOP) begin
               d.ctrl.cmd = CMD_NOP;
            end
         end else if (q.aw_addr == OFS_SWITCH) begin
            d.sw = merge(q.sw, q.w_data, q.w_strb);
         end else if (q.aw_addr == OFS_DONE) begin
            d.done_cnt = '0;
         end else if (q.aw_addr != OFS_STATUS && q.aw_addr != OFS_DISPLAY) begin
            d.bresp = RESP_SLVERR;
         end
      end

      // read channel
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         d.rvalid = 1'b1;
         d.rresp = RESP_OKAY;
         d.rdata = '0;
         if (s_axi_araddr == OFS_CTRL) begin
            d.rdata = q.ctrl;
         end else if (s_axi_araddr == OFS_STATUS) begin
            d.rdata = stat;
         end else if (s_axi_araddr == OFS_SWITCH) begin
            d.rdata = q.sw;
         end else if (s_axi_araddr == OFS_DISPLAY) begin
            d.rdata = q.disp;
         end else if (s_axi_araddr == OFS_DONE) begin
            d.rdata[DONE_W-1:0] = q.done_cnt;
         end else begin
            d.rresp = RESP_SLVERR;
         end
      end

      // sequencer
      case (q.st)
         MDT_IDLE: begin
            // waits here until a nonzero command arrives
            if (q.ctrl.cmd != CMD_NOP) begin
               d.busy = 1'b1;
               if (illegal_cmd_detect) begin
                  d.illegal = 1'b1;
                  d.st = MDT_FINAL;
               end else if (go_ok) begin
                  reserve = 1'b1;
                  d.st = MDT_XFER;
               end else begin
                  d.st = MDT_WAIT;
               end
            end
         end
         MDT_WAIT: begin
            if (go_ok) begin
               reserve = 1'b1;
               d.st = MDT_XFER;
            end
         end
         MDT_XFER: begin
            if (fire) begin
               if (q.ctrl.cmd == CMD_SR_TO_DR) begin
                  d.out.display_source_select = 1'b1;
                  d.out.display_load_gate = 1'b1;
                  finish = 1'b1;
               end else if (q.ctrl.cmd == CMD_REG_TO_DR) begin
                  d.out.reg_to_membus_enable = reg_onehot(q.ctrl.reg_sel);
                  d.out.display_source_select = 1'b0;
                  d.out.display_load_gate = 1'b1;
                  finish = 1'b1;
               end else begin
                  d.out.bbus_source_select = 1'b1;
                  d.out.bbus_to_buf_addr_enable = 1'b1;
                  d.out.mem_read_req = 1'b1;
                  d.st = MDT_READ;
               end
            end
         end
         MDT_READ: begin
            // in auto mode a free buffer means the read has finished
            if (go_ok) begin
               reserve = 1'b1;
               d.st = MDT_FINAL;
            end
         end
         MDT_FINAL: begin
            if (q.illegal) begin
               if (q.ctrl.cmd == CMD_NOP) begin
                  d.illegal = 1'b0;
                  finish = 1'b1;
               end
            end else if (fire) begin
               d.out.buf_data_to_membus_enable = 1'b1;
               d.out.display_source_select = 1'b0;
               d.out.display_load_gate = 1'b1;
               finish = 1'b1;
            end
         end
         default: begin
            d.st = MDT_IDLE;
         end
      endcase

      d.out.slot_reserve_flag = reserve;
      if (finish) begin
         d.busy = 1'b0;
         d.ctrl.cmd = CMD_NOP;
         d.st = MDT_IDLE;
         // completion wins over a clearing write in the same cycle
         d.done_cnt = q.done_cnt + 1'b1;
      end
      d.entered = d.st != q.st;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // handshakes
   assign s_axi_awready = !q.aw_have && !q.bvalid;
   assign s_axi_wready  = !q.w_have && !q.bvalid;
   assign s_axi_arready = !q.rvalid;
   // data from flops
   assign s_axi_bvalid  = q.bvalid;
   assign s_axi_bresp   = q.bresp;
   assign s_axi_rvalid  = q.rvalid;
   assign s_axi_rdata   = q.rdata;
   assign s_axi_rresp   = q.rresp;
   assign vp_out        = q.out;
endmodule

// ---- hw/mdt_pkg.sv ----
/*
   package for the maintenance display-transfer sequencer: register map,
   word layouts, command and mode codes, state set, partner-side carriers.
   assumes: AXI4-Lite with 32-bit data, one clock shared with the partner.
*/
package mdt_pkg;
   localparam int DATA_W    = 32;
   localparam int ADDR_W    = 8;
   localparam int VP_W      = 3;
   localparam int REG_TYPES = 9;
   localparam int DONE_W    = 16;

   // byte offsets of the register words
   localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SWITCH  = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DISPLAY = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_DONE    = 8'h10;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [3:0] CMD_NOP       = 4'h0;
   localparam logic [3:0] CMD_SR_TO_DR  = 4'h1;
   localparam logic [3:0] CMD_REG_TO_DR = 4'h2;
   localparam logic [3:0] CMD_MEM_TO_DR = 4'h3;

   localparam logic [1:0] MODE_MANUAL = 2'h0;
   localparam logic [1:0] MODE_SEMI   = 2'h1;
   localparam logic [1:0] MODE_AUTO   = 2'h2;

   // register field selectors
   localparam logic [3:0] RSEL_PC        = 4'h0;
   localparam logic [3:0] RSEL_NEXT_INSN = 4'h1;
   localparam logic [3:0] RSEL_CUR_INSN  = 4'h2;
   localparam logic [3:0] RSEL_BUF_ADDR  = 4'h3;
   localparam logic [3:0] RSEL_BUF_DATA  = 4'h4;
   localparam logic [3:0] RSEL_VP_REG    = 4'h5;
   localparam logic [3:0] RSEL_COMM_FILE = 4'h6;
   localparam logic [3:0] RSEL_BUF_CTL   = 4'h7;
   localparam logic [3:0] RSEL_MICRO     = 4'h8;

   // controller state numbers as seen by software
   localparam logic [2:0] SCODE_IDLE  = 3'h0;
   localparam logic [2:0] SCODE_WAIT  = 3'h4;
   localparam logic [2:0] SCODE_READ  = 3'h5;
   localparam logic [2:0] SCODE_XFER  = 3'h6;
   localparam logic [2:0] SCODE_FINAL = 3'h7;

   // clocks spent in a transfer state before its actions
   localparam logic [1:0] DWELL_MANUAL = 2'h1;
   localparam logic [1:0] DWELL_AUTO   = 2'h2;

   typedef enum logic [2:0] {
      MDT_IDLE,
      MDT_WAIT,
      MDT_XFER,
      MDT_READ,
      MDT_FINAL
   } mdt_state_type;

   typedef struct packed {
      logic [17:0]     rsvd_hi;
      logic [1:0]      mode;
      logic            rsvd_mid;
      logic [VP_W-1:0] vp;
      logic [3:0]      reg_sel;
      logic [3:0]      cmd;
   } mdt_ctrl_type;

   typedef struct packed {
      logic [25:0] rsvd;
      logic        vp_match;
      logic [2:0]  state_code;
      logic        illegal;
      logic        busy;
   } mdt_status_type;

   typedef struct packed {
      logic [VP_W-1:0]   upcoming_vp;
      logic              buffer_avail_for_vp;
      logic [DATA_W-1:0] memory_data_bus;
   } mdt_vp_in_type;

   typedef struct packed {
      logic                 slot_reserve_flag;
      logic                 display_source_select;
      logic                 display_load_gate;
      logic                 bbus_source_select;
      logic                 bbus_to_buf_addr_enable;
      logic                 buf_data_to_membus_enable;
      logic                 mem_read_req;
      logic [REG_TYPES-1:0] reg_to_membus_enable;
      logic [VP_W-1:0]      target_vp;
      logic [DATA_W-1:0]    arith_b_bus;
   } mdt_vp_out_type;
endpackage

// ---- hw/mdt_dwell_timer.sv ----
/*
   dwell timer: tells the sequencer when a transfer state has been held
   long enough for its actions (one clock manual/semi, two clocks auto).
   assumes: restart is high exactly in the first cycle of a new state.
*/
module mdt_dwell_timer (
   // clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // control
   input  wire logic restart,
   input  wire logic auto_mode,
   // result
   output logic      fire
);
   import mdt_pkg::*;

   typedef struct packed {
      logic [1:0] cnt;
   } mdt_dwell_type;

   mdt_dwell_type q;
   mdt_dwell_type d;
   logic [1:0]    elapsed;
   logic [1:0]    need;

   always_comb begin
      d = q;
      need = auto_mode ? DWELL_AUTO : DWELL_MANUAL;
      elapsed = restart ? '0 : q.cnt;
      // saturate so a late mode change cannot stall the state
      if (elapsed != '1) begin
         d.cnt = elapsed + 2'h1;
      end
      fire = elapsed >= (need - 2'h1);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ---- tb/mdt_display_seq_sva.sv ----
/*
   checker for the display-transfer sequencer: pulse shape and ordering
   of the time-slot side outputs.
   assumes: bound into mdt_display_seq, single clock domain.
*/
module mdt_display_seq_sva
   import mdt_pkg::*;
(
   // clock and reset
   input wire logic           aclk,
   input wire logic           aresetn,
   // time-slot side
   input wire mdt_vp_out_type vp_out
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_rd_pulse;
      vp_out.mem_read_req && vp_out.bbus_to_buf_addr_enable && vp_out.bbus_source_select;
   endsequence
   sequence s_buf_load;
      vp_out.buf_data_to_membus_enable && vp_out.display_load_gate
         && !vp_out.display_source_select;
   endsequence

   AST_READ_GROUP: assert property (
      vp_out.mem_read_req |-> s_rd_pulse) else $error("read request alone");
   AST_READ_TO_LOAD: assert property (
      s_rd_pulse |-> ##[2:1000] s_buf_load) else $error("read word never loaded");
   AST_BUF_LOAD: assert property (
      vp_out.buf_data_to_membus_enable |-> s_buf_load) else $error("buffer data not loaded");
   AST_LOAD_PULSE: assert property (
      vp_out.display_load_gate |=> !vp_out.display_load_gate) else $error("long load gate");
   AST_RESERVE_PULSE: assert property (
      vp_out.slot_reserve_flag |=> !vp_out.slot_reserve_flag) else $error("long reserve");
   AST_LOAD_AFTER_RESERVE: assert property (
      vp_out.display_load_gate |->
         $past(vp_out.slot_reserve_flag) || $past(vp_out.slot_reserve_flag, 2))
      else $error("load without reserved slot");
   AST_SWITCH_SOURCE: assert property (
      vp_out.display_load_gate && vp_out.display_source_select |->
         vp_out.reg_to_membus_enable == '0 && !vp_out.buf_data_to_membus_enable)
      else $error("bus driven on switch copy");
   AST_REG_ONEHOT: assert property (
      vp_out.reg_to_membus_enable != '0 |-> $onehot(vp_out.reg_to_membus_enable)
         && vp_out.display_load_gate && !vp_out.display_source_select)
      else $error("bad register enable");
   AST_READ_NO_LOAD: assert property (
      vp_out.mem_read_req |-> !vp_out.display_load_gate && !vp_out.slot_reserve_flag)
      else $error("load during read request");
endmodule

bind mdt_display_seq mdt_display_seq_sva u_sva (.aclk, .aresetn, .vp_out);

// ---- tb/mdt_vp_partner.sv ----
/*
   time-slot and buffer model: rotating upcoming vp, buffer busy during
   a read, register and buffer words on the memory bus.
   assumes: same clock as the sequencer.
*/
module mdt_vp_partner
   import mdt_pkg::*;
(
   // clock and reset
   input  wire logic           aclk,
   input  wire logic           aresetn,
   // bench control
   input  wire logic           freeze,
   input  wire logic           stall,
   // sequencer side
   input  wire mdt_vp_out_type vp_out,
   output mdt_vp_in_type       vp_in,
   output logic [DATA_W-1:0]   buf_addr
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [VP_W-1:0]   slot_q;
   logic [2:0]        rd_q;
   logic [DATA_W-1:0] noise_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_q   <= '0;
         rd_q     <= '0;
         buf_addr <= '0;
         noise_q  <= 32'h0F0F_1234;
      end else begin
         slot_q  <= freeze ? '0 : slot_q + 3'h1;
         noise_q <= ~noise_q + 32'h0000_0007;
         if (vp_out.bbus_to_buf_addr_enable)
            buf_addr <= vp_out.arith_b_bus;
         // read keeps the buffer busy for a few slots
         if (vp_out.mem_read_req)
            rd_q <= 3'h5;
         else if (rd_q != 3'h0)
            rd_q <= rd_q - 3'h1;
      end
   end

   always_comb begin
      vp_in.upcoming_vp         = slot_q;
      // buffer counts as busy from the request cycle on
      vp_in.buffer_avail_for_vp = !stall && rd_q == 3'h0 && !vp_out.mem_read_req;
      // undriven bus shows a changing pattern, never a stale word
      vp_in.memory_data_bus     = noise_q;
      if (vp_out.buf_data_to_membus_enable)
         vp_in.memory_data_bus = ~buf_addr;
      for (int i = 0; i < REG_TYPES; i++)
         if (vp_out.reg_to_membus_enable[i])
            vp_in.memory_data_bus = {28'hA000000, 4'(i)};
   end
endmodule

// ---- tb/test_mdt_display_seq.sv ----
/*
   testbench for the display-transfer sequencer: register bus tasks and
   one task per command scenario, against the time-slot model.
   assumes: package, design, model and checker compiled first.
*/
module test_mdt_display_seq
   import mdt_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic                 aclk, aresetn, freeze, stall;
   logic                 s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic                 s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic                 s_axi_rvalid, s_axi_rready;
   logic [ADDR_W-1:0]    s_axi_awaddr, s_axi_araddr;
   logic [DATA_W-1:0]    s_axi_wdata, s_axi_rdata, buf_addr, d, sw;
   logic [3:0]           s_axi_wstrb;
   logic [1:0]           s_axi_bresp, s_axi_rresp, rs;
   mdt_vp_in_type        vp_in;
   mdt_vp_out_type       vp_out;
   mdt_status_type       st;
   logic                 sel;
   logic [VP_W-1:0]      tvp;
   logic [REG_TYPES-1:0] ren;
   int                   err_count, total_checks, cyc, res_cyc, gap, n_load, n0;

   mdt_display_seq dut (.*);
   mdt_vp_partner u_partner (.aclk, .aresetn, .freeze, .stall, .vp_out, .vp_in, .buf_addr);

   initial begin
      aclk = 1'h0;
      forever #4 aclk = ~aclk;
   end

   // load gate timing relative to the last slot reservation
   always @(negedge aclk) begin
      cyc++;
      if (vp_out.slot_reserve_flag) res_cyc = cyc;
      if (vp_out.bbus_to_buf_addr_enable) tvp = vp_out.target_vp;
      if (vp_out.display_load_gate) begin
         n_load++;
         gap = cyc - res_cyc;
         sel = vp_out.display_source_select;
         ren = vp_out.reg_to_membus_enable;
      end
   end

   task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // readies are settled at the falling edge, handshakes land on the rising
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      logic ta, tw, tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(negedge aclk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         rs = s_axi_bresp;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'h0;
         if (tw) s_axi_wvalid <= 1'h0;
      end while (!tb);
      s_axi_bready <= 1'h0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] a);
      logic ta, tr;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(negedge aclk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         rs = s_axi_rresp;
         @(posedge aclk);
         if (ta) s_axi_arvalid <= 1'h0;
      end while (!tr);
      s_axi_rready <= 1'h0;
      st = d;
   endtask

   task automatic cmd(input logic [3:0] c, input logic [3:0] r, input logic [2:0] v,
                      input logic [1:0] m);
      mdt_ctrl_type ct;
      ct = '0;
      ct.cmd = c;
      ct.reg_sel = r;
      ct.vp = v;
      ct.mode = m;
      wr(OFS_CTRL, ct);
   endtask

   task automatic wait_idle;
      do rd(OFS_STATUS); while (st.busy !== 1'h0 || st.state_code !== SCODE_IDLE);
   endtask

   task automatic t_bus;
      rd(OFS_STATUS);
      chk("status after reset", 32'h0, d);
      chk("read response", RESP_OKAY, rs);
      cmd(4'h4, 4'h0, 3'h0, MODE_MANUAL);
      chk("write response", RESP_OKAY, rs);
      rd(OFS_CTRL);
      chk("refused command", 32'h0, d);
      wr(8'h40, 32'hFFFF_FFFF);
      chk("unmapped write", RESP_SLVERR, rs);
      rd(8'h40);
      chk("unmapped read", {30'h0, RESP_SLVERR}, {d[29:0], rs});
   endtask

   task automatic t_switch_copy;
      // mode code 3 runs as a non-auto mode
      for (int m = 0; m < 4; m++) begin
         sw = 32'h5A00_00C0 + DATA_W'(m);
         wr(OFS_SWITCH, sw);
         freeze <= (m == 2);
         cmd(CMD_SR_TO_DR, 4'h0, 3'h5, 2'(m));
         if (m == 2) begin
            rd(OFS_STATUS);
            chk("auto wait", {SCODE_WAIT, 2'h1}, d[4:0]);
            freeze <= 1'h0;
         end
         wait_idle;
         rd(OFS_DISPLAY);
         chk("switch copy", sw, d);
         chk("switch source", 1, sel);
         chk("switch dwell", (m == 2) ? 2 : 1, gap);
      end
   endtask

   task automatic t_reg_copy;
      for (int n = 0; n <= REG_TYPES; n++) begin
         cmd(CMD_REG_TO_DR, 4'(n % REG_TYPES), 3'h2, (n < REG_TYPES) ? MODE_SEMI : MODE_AUTO);
         wait_idle;
         rd(OFS_DISPLAY);
         chk("register copy", {28'hA000000, 4'(n % REG_TYPES)}, d);
         chk("register enable", 1 << (n % REG_TYPES), ren);
      end
      chk("register dwell auto", 2, gap);
   endtask

   task automatic t_illegal;
      n0 = n_load;
      // micro register in auto, then a selector past the last register
      for (int k = 0; k < 2; k++) begin
         cmd(CMD_REG_TO_DR, (k == 0) ? RSEL_MICRO : 4'h9, 3'h1,
             (k == 0) ? MODE_AUTO : MODE_SEMI);
         rd(OFS_STATUS);
         chk("illegal state", {SCODE_FINAL, 2'h3}, d[4:0]);
         cmd(CMD_SR_TO_DR, 4'h0, 3'h1, MODE_MANUAL);
         rd(OFS_STATUS);
         chk("illegal holds", {SCODE_FINAL, 2'h3}, d[4:0]);
         cmd(CMD_NOP, 4'h0, 3'h1, MODE_AUTO);
         rd(OFS_STATUS);
         chk("illegal cleared", 5'h0, d[4:0]);
      end
      chk("no transfer", n0, n_load);
   endtask

   task automatic t_mem_copy(input logic [1:0] m);
      sw = 32'h0000_0AB0 ^ {30'h0, m};
      wr(OFS_SWITCH, sw);
      stall <= (m == MODE_AUTO);
      wr(OFS_DONE, 32'h0);
      chk("done clear response", RESP_OKAY, rs);
      cmd(CMD_MEM_TO_DR, 4'h0, 3'h3, m);
      if (m == MODE_AUTO) begin
         rd(OFS_STATUS);
         chk("buffer wait", {SCODE_WAIT, 2'h1}, d[4:0]);
         stall <= 1'h0;
      end
      wait_idle;
      rd(OFS_DISPLAY);
      chk("memory copy", ~sw, d);
      chk("buffer address", sw, buf_addr);
      chk("target vp", 3'h3, tvp);
      rd(OFS_DONE);
      chk("done count", 32'h1, d);
      chk("memory dwell", (m == MODE_AUTO) ? 2 : 1, gap);
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #200000;
      err_count++;
      final_report;
   end

   initial begin
      {aresetn, freeze, stall, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      t_bus;
      t_switch_copy;
      t_reg_copy;
      t_illegal;
      t_mem_copy(MODE_MANUAL);
      t_mem_copy(MODE_SEMI);
      t_mem_copy(MODE_AUTO);
      final_report;
   end
endmodule
